// File: core/uhs_pkg.sv
// package: register map, field layout and carrier types of the host status block
package uhs_pkg;
  // ********************************************************************
  // register byte offsets
  // ********************************************************************
  localparam logic [7:0] OFS_CONTROL = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_EN = 8'h28;
  localparam logic [7:0] OFS_FRAME_INDEX = 8'h2C;
  localparam logic [7:0] OFS_PERIODIC_BASE = 8'h34;
  localparam logic [7:0] OFS_ASYNC_ADDR = 8'h38;
  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int CTL_RUN = 0;
  localparam int CTL_SIZE_LO = 2;
  localparam int CTL_PERIODIC_EN = 4;
  localparam int CTL_ASYNC_EN = 5;
  localparam int CTL_DOORBELL = 6;
  localparam int CTL_THR_LO = 16;
  localparam int STS_RECLAIM = 13;
  localparam int STS_HALTED = 12;
  localparam int STS_PERIODIC_RUN = 14;
  localparam int STS_ASYNC_RUN = 15;
  localparam int FLG_DONE = 0;
  localparam int FLG_ERROR = 1;
  localparam int FLG_PORT = 2;
  localparam int FLG_ROLL = 3;
  localparam int FLG_SYSERR = 4;
  localparam int FLG_ADVANCE = 5;
  localparam int NUM_FLAGS = 6;
  localparam int FIDX_W = 14;
  localparam int PBASE_LO = 12;
  localparam int APTR_LO = 5;
  // ********************************************************************
  // reset values, masks and counts
  // ********************************************************************
  localparam logic [7:0] THR_RESET = 8'h08;
  localparam logic [1:0] SIZE_1024 = 2'h0;
  localparam logic [1:0] SIZE_512 = 2'h1;
  localparam logic [1:0] SIZE_256 = 2'h2;
  localparam logic [5:0] GATED_MASK = 6'h23;
  localparam logic [4:0] HALT_UFRAMES = 5'h10;
  // ********************************************************************
  // carriers
  // ********************************************************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } uhs_wb_req_t;
  typedef struct packed {
    logic uframe_end;
    logic advanced;
    logic sys_error;
    logic port_change;
    logic power_resume;
    logic port_change_any;
    logic td_error;
    logic td_ioc_done;
    logic short_packet;
    logic reclaim;
    logic pipe_idle;
    logic fatal_error;
  } uhs_event_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic run;
    logic async_en;
    logic periodic_en;
    logic doorbell;
    logic [1:0] list_size_code;
    logic [7:0] irq_threshold_setting;
    logic async_sched_running;
    logic periodic_sched_running;
    logic halted_flag;
    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] irq_en;
    logic [FIDX_W-1:0] micro_frame_counter;
    logic [31:PBASE_LO] periodic_base_bits;
    logic [31:APTR_LO] async_pointer_bits;
    logic [6:0] thr_cnt;
    logic gated_hit;
    logic [4:0] halt_cnt;
    logic irq;
    logic [31:0] entry_addr;
  } uhs_state_t;
endpackage

// File: core/uhs_status_core.sv
// module: status, interrupt, frame index and list pointer registers of a usb host
//
// Behaviour
// (RQ1) async running bit follows async enable with lag; settled when equal
// (RQ2) periodic running bit follows periodic enable with lag; settled when equal
// (RQ3) read-only reclamation bit reports empty async schedule detection
// (RQ4) halted reads zero while running; set once execution actually stopped
// (RQ5) after doorbell, set async advance flag at next schedule advance
// (RQ6) set system error flag on serious system bus access error
// (RQ7) set rollover flag when index bit 13 (1024) or 12 (512) toggles
// (RQ8) set port change flag on owned port change or resume rise
// (RQ9) also set port change flag on connect change after ownership handover
// (RQ10) on power return load port change flag with OR of port change bits
// (RQ11) set error flag on failed transaction; with completion request set both
// (RQ12) set completion flag when descriptor with completion request retires
// (RQ13) set completion flag also on a short packet
// (RQ14) event flags clear only on software writing one; zero leaves them
// (RQ15) advance, error and completion interrupts wait for threshold boundary
// (RQ16) system error, rollover and port change interrupts are immediate
// (RQ17) enable bits gate their sources; all reset to zero
// (RQ18) fourteen bit frame index increments every micro-frame, resets zero
// (RQ19) entry index is index bits N:3, N 12/11/10 by size code
// (RQ20) periodic base holds address bits 31:12, low bits reserved
// (RQ21) async address holds bits 31:5, low bits reserved, queue heads only
// (RQ22) halt within 16 micro-frames after run cleared
// (RQ23) threshold defaults to 8 micro-frames; 1 to 64 allowed
// (RQ24) doorbell clears itself once advance flag is set
// (RQ25) status resets with only the halted bit set
// (RQ26) for 256 entries set rollover on every toggle of index bit 11
// (RQ27) one interrupt output active while any enabled flag is set
`timescale 1ns/1ps
`default_nettype none
module uhs_status_core (
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic I_CLK_EN,
  input wire uhs_pkg::uhs_wb_req_t I_WB_REQ,
  input wire uhs_pkg::uhs_event_t I_EVENT,
  output logic O_WB_ACK,
  output logic [31:0] O_WB_DAT,
  output logic O_IRQ,
  output logic O_RUN,
  output logic O_HALTED,
  output logic O_ASYNC_RUNNING,
  output logic O_PERIODIC_RUNNING,
  output logic [31:0] O_ASYNC_LIST_ADDR,
  output logic [31:0] O_FRAME_ENTRY_ADDR
);
  import uhs_pkg::*;

  uhs_state_t st_r;
  uhs_state_t st_nxt;

  // ********************************************************************
  // helpers
  // ********************************************************************
  // byte lane mask from wishbone select
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // read mux over the register map
  function automatic logic [31:0] read_word(input uhs_state_t s, input logic [7:0] adr,
                                            input logic reclaim);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (adr)
      OFS_CONTROL: begin
        w[CTL_RUN] = s.run;
        w[CTL_SIZE_LO +: 2] = s.list_size_code;
        w[CTL_PERIODIC_EN] = s.periodic_en;
        w[CTL_ASYNC_EN] = s.async_en;
        w[CTL_DOORBELL] = s.doorbell;
        w[CTL_THR_LO +: 8] = s.irq_threshold_setting;
      end
      OFS_STATUS: begin
        w[NUM_FLAGS-1:0] = s.flags;
        w[STS_HALTED] = s.halted_flag;
        w[STS_RECLAIM] = reclaim; // see RQ3
        w[STS_PERIODIC_RUN] = s.periodic_sched_running;
        w[STS_ASYNC_RUN] = s.async_sched_running;
      end
      OFS_IRQ_EN: w[NUM_FLAGS-1:0] = s.irq_en;
      OFS_FRAME_INDEX: w[FIDX_W-1:0] = s.micro_frame_counter;
      OFS_PERIODIC_BASE: w[31:PBASE_LO] = s.periodic_base_bits;
      OFS_ASYNC_ADDR: w[31:APTR_LO] = s.async_pointer_bits;
      default: w = 32'h0000_0000; // unmapped reads as zero
    endcase
    read_word = w;
  endfunction

  // ********************************************************************
  // next state
  // ********************************************************************
  logic req;
  logic wr;
  logic [31:0] wm;
  logic [31:0] wd;
  logic [NUM_FLAGS-1:0] set_flags;
  logic [NUM_FLAGS-1:0] clr_flags;
  logic [NUM_FLAGS-1:0] pend;
  logic [FIDX_W-1:0] fidx_inc;
  logic tick;
  logic wrap;
  logic boundary;
  logic [6:0] thr_lim;
  logic [9:0] entry_idx;
  logic ring;

  // bus decode, register writes, event flags, counters and interrupt
  always_comb begin
    st_nxt = st_r;
    req = I_WB_REQ.cyc & I_WB_REQ.stb;
    wm = lane_mask(I_WB_REQ.sel);
    wd = I_WB_REQ.dat;
    // write lands on the edge where the master sees ack
    wr = req & I_WB_REQ.we & st_r.ack;
    // software rings the doorbell in this very cycle
    ring = wr & (I_WB_REQ.adr == OFS_CONTROL) & wm[CTL_DOORBELL] & wd[CTL_DOORBELL];
    tick = I_EVENT.uframe_end & ~st_r.halted_flag;
    fidx_inc = st_r.micro_frame_counter + 14'h0001;
    set_flags = '0;
    clr_flags = '0;
    wrap = 1'b0;
    boundary = 1'b0;
    entry_idx = 10'h000;
    thr_lim = (st_r.irq_threshold_setting[6:0] == 7'h00) ? 7'h01
              : st_r.irq_threshold_setting[6:0];

    // single cycle ack, dropped the cycle after it was given
    st_nxt.ack = req & ~st_r.ack;
    st_nxt.rdat = (req & ~st_r.ack) ? read_word(st_r, I_WB_REQ.adr, I_EVENT.reclaim)
                                      : 32'h0000_0000;

    // software writes with byte lanes
    if (wr) begin
      unique case (I_WB_REQ.adr)
        OFS_CONTROL: begin
          if (wm[CTL_RUN]) st_nxt.run = wd[CTL_RUN];
          if (wm[CTL_SIZE_LO]) st_nxt.list_size_code = wd[CTL_SIZE_LO +: 2];
          if (wm[CTL_PERIODIC_EN]) st_nxt.periodic_en = wd[CTL_PERIODIC_EN];
          if (wm[CTL_ASYNC_EN]) st_nxt.async_en = wd[CTL_ASYNC_EN];
          if (wm[CTL_DOORBELL] & wd[CTL_DOORBELL]) st_nxt.doorbell = 1'b1;
          if (wm[CTL_THR_LO]) st_nxt.irq_threshold_setting = wd[CTL_THR_LO +: 8];
        end
        OFS_STATUS: clr_flags = wd[NUM_FLAGS-1:0] & wm[NUM_FLAGS-1:0]; // see RQ14
        OFS_IRQ_EN: st_nxt.irq_en = (st_r.irq_en & ~wm[NUM_FLAGS-1:0])
                                    | (wd[NUM_FLAGS-1:0] & wm[NUM_FLAGS-1:0]); // see RQ17
        OFS_FRAME_INDEX: st_nxt.micro_frame_counter = (st_r.micro_frame_counter
                           & ~wm[FIDX_W-1:0]) | (wd[FIDX_W-1:0] & wm[FIDX_W-1:0]);
        OFS_PERIODIC_BASE: st_nxt.periodic_base_bits = (st_r.periodic_base_bits
                             & ~wm[31:PBASE_LO]) | (wd[31:PBASE_LO] & wm[31:PBASE_LO]); // see RQ20
        OFS_ASYNC_ADDR: st_nxt.async_pointer_bits = (st_r.async_pointer_bits
                          & ~wm[31:APTR_LO]) | (wd[31:APTR_LO] & wm[31:APTR_LO]); // see RQ21
        default: st_nxt.irq_en = st_nxt.irq_en; // unmapped writes are dropped
      endcase
    end

    // internal error stops the controller like a software stop
    if (I_EVENT.fatal_error) st_nxt.run = 1'b0;

    // halt tracking: run clears halted at once, stop waits for pipeline drain or the micro-frame bound
    if (st_nxt.run) begin
      st_nxt.halted_flag = 1'b0; // see RQ4
      st_nxt.halt_cnt = 5'h00;
    end else if (~st_r.halted_flag) begin
      if (I_EVENT.pipe_idle | (st_r.halt_cnt >= HALT_UFRAMES - 5'h01)) begin
        st_nxt.halted_flag = 1'b1; // see RQ4
      end else if (I_EVENT.uframe_end) begin
        st_nxt.halt_cnt = st_r.halt_cnt + 5'h01; // see RQ22
      end
    end

    // schedule status follows enables at micro-frame edges, off when halted
    if (st_r.halted_flag) begin
      st_nxt.async_sched_running = 1'b0;
      st_nxt.periodic_sched_running = 1'b0;
    end else if (I_EVENT.uframe_end) begin
      st_nxt.async_sched_running = st_r.async_en; // see RQ1
      st_nxt.periodic_sched_running = st_r.periodic_en; // see RQ2
    end

    // frame index and rollover at the size dependent bit
    if (tick) begin
      st_nxt.micro_frame_counter = fidx_inc; // see RQ18
      unique case (st_r.list_size_code)
        SIZE_512: wrap = fidx_inc[12] ^ st_r.micro_frame_counter[12]; // see RQ7
        SIZE_256: wrap = fidx_inc[11] ^ st_r.micro_frame_counter[11]; // see RQ26
        default: wrap = fidx_inc[13] ^ st_r.micro_frame_counter[13]; // see RQ7
      endcase
    end

    // threshold counter gives the boundary for gated sources
    if (tick) begin
      if (st_r.thr_cnt + 7'h01 >= thr_lim) begin
        st_nxt.thr_cnt = 7'h00;
        boundary = 1'b1; // see RQ23
      end else begin
        st_nxt.thr_cnt = st_r.thr_cnt + 7'h01;
      end
    end

    // event sources
    set_flags[FLG_ADVANCE] = st_r.doorbell & I_EVENT.advanced; // see RQ5
    set_flags[FLG_SYSERR] = I_EVENT.sys_error; // see RQ6
    set_flags[FLG_ROLL] = wrap; // see RQ7
    set_flags[FLG_PORT] = I_EVENT.port_change // see RQ8 RQ9
                          | (I_EVENT.power_resume & I_EVENT.port_change_any); // see RQ10
    set_flags[FLG_ERROR] = I_EVENT.td_error; // see RQ11
    set_flags[FLG_DONE] = I_EVENT.td_ioc_done | I_EVENT.short_packet; // see RQ12 RQ13
    // a ring in the cycle of the hardware clear wins
    if (set_flags[FLG_ADVANCE] & ~ring) st_nxt.doorbell = 1'b0; // see RQ24

    // a set in the cycle of the clear wins
    st_nxt.flags = (st_r.flags & ~clr_flags) | set_flags; // see RQ14

    // gated sources latch only at a boundary and drop once all acknowledged
    pend = st_nxt.flags & st_nxt.irq_en;
    if ((pend & GATED_MASK) == '0) st_nxt.gated_hit = 1'b0;
    else if (boundary) st_nxt.gated_hit = 1'b1; // see RQ15
    st_nxt.irq = ((pend & ~GATED_MASK) != '0) | st_nxt.gated_hit; // see RQ16 RQ27

    // frame list entry address, index bits N:3 by size code
    unique case (st_nxt.list_size_code)
      SIZE_512: entry_idx = {1'b0, st_nxt.micro_frame_counter[11:3]}; // see RQ19
      SIZE_256: entry_idx = {2'b00, st_nxt.micro_frame_counter[10:3]};
      default: entry_idx = st_nxt.micro_frame_counter[12:3];
    endcase
    st_nxt.entry_addr = {st_nxt.periodic_base_bits, entry_idx, 2'b00};
  end

  // ********************************************************************
  // state register
  // ********************************************************************
  // whole state, frozen while the clock enable is low
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_r <= '0;
      st_r.halted_flag <= 1'b1; // see RQ25
      st_r.irq_threshold_setting <= THR_RESET; // see RQ23
    end else if (I_CLK_EN) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign O_WB_ACK = st_r.ack;
  assign O_WB_DAT = st_r.rdat;
  assign O_IRQ = st_r.irq;
  assign O_RUN = st_r.run;
  assign O_HALTED = st_r.halted_flag;
  assign O_ASYNC_RUNNING = st_r.async_sched_running;
  assign O_PERIODIC_RUNNING = st_r.periodic_sched_running;
  assign O_ASYNC_LIST_ADDR = {st_r.async_pointer_bits, 5'h00};
  assign O_FRAME_ENTRY_ADDR = st_r.entry_addr;

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);

  // halt and run never both read as one
  a_halted_vs_run: assert property (st_r.run |-> !st_r.halted_flag) // see RQ4
    else $error("halted set while running");
  // the stop counter never runs past its bound
  a_halt_bound_met: assert property (st_r.halt_cnt <= HALT_UFRAMES) // see RQ22
    else $error("halt counter past bound");
  // a run write clears halted at the same edge
  a_run_clears_halt: assert property (I_CLK_EN && st_nxt.run |=> !O_HALTED) // see RQ4
    else $error("halted kept after run");
  // a drained pipeline halts a stopped controller
  a_idle_halts: assert property ( // see RQ4 RQ22
    I_CLK_EN && !st_nxt.run && I_EVENT.pipe_idle |=> O_HALTED)
    else $error("drained pipeline did not halt");

  // schedule status is forced off while halted
  a_sched_off_halt: assert property ( // see RQ1 RQ2
    I_CLK_EN && st_r.halted_flag |=> !O_ASYNC_RUNNING && !O_PERIODIC_RUNNING)
    else $error("schedule status on while halted");
  // status bits copy the enables at a micro-frame end
  a_async_follows: assert property ( // see RQ1
    I_CLK_EN && !st_r.halted_flag && I_EVENT.uframe_end
    |=> O_ASYNC_RUNNING == $past(st_r.async_en))
    else $error("async status did not follow enable");
  a_periodic_follows: assert property ( // see RQ2
    I_CLK_EN && !st_r.halted_flag && I_EVENT.uframe_end
    |=> O_PERIODIC_RUNNING == $past(st_r.periodic_en))
    else $error("periodic status did not follow enable");

  // ********************************************************************
  // checks on event flags
  // ********************************************************************
  // a flag stays set until software writes a one to it
  a_flag_sticky: assert property ( // see RQ14
    I_CLK_EN && !(wr && I_WB_REQ.adr == OFS_STATUS) && st_r.flags[FLG_SYSERR]
    |=> st_r.flags[FLG_SYSERR])
    else $error("event flag lost without a clear");
  // a write of one clears a flag that no event sets again
  a_w1c_clears: assert property ( // see RQ14
    I_CLK_EN && clr_flags[FLG_ROLL] && !set_flags[FLG_ROLL] |=> !st_r.flags[FLG_ROLL])
    else $error("write of one did not clear flag");
  // an event in the cycle of a clear still lands
  a_set_wins: assert property ( // see RQ14
    I_CLK_EN && |set_flags |=> (st_r.flags & $past(set_flags)) == $past(set_flags))
    else $error("event flag lost to a clear");

  // each event shows in its flag one edge later
  a_syserr_sets: assert property ( // see RQ6
    I_CLK_EN && I_EVENT.sys_error |=> st_r.flags[FLG_SYSERR])
    else $error("system error not flagged");
  a_port_sets: assert property ( // see RQ8 RQ9
    I_CLK_EN && I_EVENT.port_change |=> st_r.flags[FLG_PORT])
    else $error("port change not flagged");
  a_error_sets: assert property ( // see RQ11
    I_CLK_EN && I_EVENT.td_error |=> st_r.flags[FLG_ERROR])
    else $error("transaction error not flagged");
  a_done_sets: assert property ( // see RQ12 RQ13
    I_CLK_EN && (I_EVENT.td_ioc_done || I_EVENT.short_packet) |=> st_r.flags[FLG_DONE])
    else $error("completion not flagged");
  a_rollover_sets: assert property ( // see RQ7 RQ26
    I_CLK_EN && wrap |=> st_r.flags[FLG_ROLL])
    else $error("rollover not flagged");

  // the doorbell clears itself once the advance flag is set
  a_doorbell_clear: assert property ( // see RQ24
    I_CLK_EN && st_r.doorbell && I_EVENT.advanced && !ring
    |=> !st_r.doorbell && st_r.flags[FLG_ADVANCE])
    else $error("doorbell not cleared on advance");
  // a ring in the cycle of the hardware clear is kept
  a_ring_kept: assert property (I_CLK_EN && ring |=> st_r.doorbell) // see RQ24
    else $error("doorbell ring lost");
  // an advance with no doorbell rung sets nothing
  a_advance_needs_bell: assert property ( // see RQ5
    I_CLK_EN && !st_r.doorbell && !st_r.flags[FLG_ADVANCE] |=> !st_r.flags[FLG_ADVANCE])
    else $error("advance flag without doorbell");

  // ********************************************************************
  // checks on interrupt, frame index and bus
  // ********************************************************************
  // ungated sources raise the interrupt at once
  a_immediate_irq: assert property ( // see RQ16
    I_CLK_EN && st_nxt.flags[FLG_PORT] && st_nxt.irq_en[FLG_PORT] |=> O_IRQ)
    else $error("port change interrupt delayed");
  // gated sources wait for the threshold boundary
  a_gated_wait: assert property ( // see RQ15
    I_CLK_EN && $rose(O_IRQ) && ((st_r.flags & st_r.irq_en & ~GATED_MASK) == '0)
    |-> $past(boundary))
    else $error("gated interrupt before boundary");
  // no interrupt without an enabled flag behind it
  a_irq_needs_en: assert property ( // see RQ17 RQ27
    O_IRQ |-> (st_r.flags & st_r.irq_en) != '0)
    else $error("interrupt with no enabled flag");

  // the index steps once per micro-frame tick
  a_index_step: assert property ( // see RQ18
    I_CLK_EN && tick && !wr
    |=> st_r.micro_frame_counter == $past(st_r.micro_frame_counter) + 14'h0001)
    else $error("frame index did not step");
  // the index stands still while halted
  a_index_halted: assert property ( // see RQ18
    I_CLK_EN && st_r.halted_flag && !wr |=> $stable(st_r.micro_frame_counter))
    else $error("frame index moved while halted");
  // ack is a single cycle pulse
  a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held longer than one cycle");

  // main scenarios
  c_power_resume: cover property (I_EVENT.power_resume && I_EVENT.port_change_any);
  c_rollover: cover property (st_r.flags[FLG_ROLL]);
  c_halt_after_run: cover property (st_r.run ##[1:200] st_r.halted_flag);
  c_gated_irq: cover property (boundary && st_nxt.gated_hit);
  c_clear_and_set: cover property (wr && |clr_flags && |set_flags);
endmodule
`default_nettype wire

// File: tb/uhs_far_side.sv
// far-side model: schedule engine, ports and memory events feeding the status block
`timescale 1ns/1ps
`default_nettype none
module uhs_far_side (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_run,
  input wire logic i_slow,
  input wire uhs_pkg::uhs_event_t i_cmd,
  output var uhs_pkg::uhs_event_t o_event
);
  import uhs_pkg::*;
  logic [1:0] drain_r;
  // ********************************************************************
  // event launch and pipeline drain
  // ********************************************************************
  // pulses leave one edge after the command; a slow engine never drains
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      drain_r <= 2'h0;
      o_event <= '0;
    end else begin
      drain_r <= i_run ? 2'h0 : ((drain_r == 2'h3) ? drain_r : drain_r + 2'h1);
      o_event <= i_cmd;
      o_event.pipe_idle <= !i_run && !i_slow && (drain_r == 2'h3); // idle only once drained
    end
  end
endmodule
`default_nettype wire

// File: tb/usb_host_status_interrupt_frame_index_tb.sv
// self-checking bench for the usb host status, interrupt and frame index block
`timescale 1ns/1ps
`default_nettype none
module usb_host_status_interrupt_frame_index_tb;
  import uhs_pkg::*;
  logic clk;
  logic rstn;
  logic slow;
  logic clk_en;
  uhs_wb_req_t req;
  uhs_event_t cmd;
  uhs_event_t ev;
  logic ack, irq, run, halted, arun, prun;
  logic [31:0] rdat, q, aaddr, entry;
  int mismatches;
  int check_count;
  uhs_status_core uut (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_CLK_EN(clk_en), .I_WB_REQ(req),
    .I_EVENT(ev), .O_WB_ACK(ack), .O_WB_DAT(rdat), .O_IRQ(irq), .O_RUN(run),
    .O_HALTED(halted), .O_ASYNC_RUNNING(arun), .O_PERIODIC_RUNNING(prun),
    .O_ASYNC_LIST_ADDR(aaddr), .O_FRAME_ENTRY_ADDR(entry));
  uhs_far_side far (.i_clk(clk), .i_rstn(rstn), .i_run(run), .i_slow(slow), .i_cmd(cmd),
    .o_event(ev));
  // ********************************************************************
  // shared tasks
  // ********************************************************************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  // classic single cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    if (n >= 40) begin
      $display("ERROR t=%0t bus wait ran out %h %h", $time, a, d);
      mismatches++;
    end
    req <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic pulse(input logic [11:0] e);
    cmd <= uhs_event_t'(e);
    @(posedge clk);
    cmd <= '0;
    repeat (3) @(posedge clk);
  endtask
  task automatic uf(input int n);
    repeat (n) pulse(12'h800);
  endtask
  function automatic logic [31:0] ctl(input logic r, input logic [1:0] s, input logic pe,
    input logic ae, input logic db);
    return {8'h00, THR_RESET, 8'h00, 1'b0, db, ae, pe, s, 1'b0, r};
  endfunction
  // ********************************************************************
  // scenarios
  // ********************************************************************
  task automatic t_reset;
    rdm(OFS_STATUS, 32'hFFFFFFFF, 32'h00001000);
    rdm(OFS_IRQ_EN, 32'hFFFFFFFF, 32'h0);
    rdm(OFS_CONTROL, 32'hFFFFFFFF, 32'h00080000);
    rdm(OFS_FRAME_INDEX, 32'hFFFFFFFF, 32'h0);
    rdm(OFS_PERIODIC_BASE, 32'hFFFFFFFF, 32'h0);
    rdm(OFS_ASYNC_ADDR, 32'hFFFFFFFF, 32'h0);
    chk({30'h0, halted, irq}, 32'h2);
  endtask
  task automatic t_regs;
    wr(OFS_PERIODIC_BASE, 32'hFFFFFFFF);
    rdm(OFS_PERIODIC_BASE, 32'hFFFFFFFF, 32'hFFFFF000);
    wr(OFS_ASYNC_ADDR, 32'h12345678); // queue head pointer
    rdm(OFS_ASYNC_ADDR, 32'hFFFFFFFF, 32'h12345660);
    chk(aaddr, 32'h12345660);
    wr(OFS_IRQ_EN, 32'hFFFFFFFF);
    rdm(OFS_IRQ_EN, 32'hFFFFFFFF, 32'h3F);
    wr(OFS_IRQ_EN, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rdm(8'h40, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic t_run;
    wr(OFS_CONTROL, ctl(1'b1, SIZE_1024, 1'b1, 1'b1, 1'b0));
    chk({30'h0, run, halted}, 32'h2);
    wr(OFS_FRAME_INDEX, 32'h0);
    uf(3);
    rdm(OFS_FRAME_INDEX, 32'hFFFFFFFF, 32'h3);
    clk_en <= 1'b0;
    uf(1);
    clk_en <= 1'b1;
    rdm(OFS_FRAME_INDEX, 32'hFFFFFFFF, 32'h3);
    rdm(OFS_STATUS, 32'hF000, 32'hC000);
    wr(OFS_CONTROL, ctl(1'b1, SIZE_1024, 1'b0, 1'b1, 1'b0));
    uf(1);
    rdm(OFS_STATUS, 32'hC000, 32'h8000);
    chk({30'h0, arun, prun}, 32'h2);
  endtask
  task automatic t_roll;
    logic [31:0] f;
    for (int s = 0; s < 3; s++) begin
      f = (32'h1 << (13 - s)) - 32'h1;
      wr(OFS_CONTROL, ctl(1'b1, 2'(s), 1'b1, 1'b1, 1'b0));
      wr(OFS_FRAME_INDEX, f);
      wr(OFS_STATUS, 32'h3F);
      rdm(OFS_STATUS, 32'h08, 32'h0);
      chk(entry, 32'hFFFFF000 | (((32'h1 << (10 - s)) - 32'h1) << 2));
      uf(1);
      rdm(OFS_STATUS, 32'h08, 32'h08);
      rdm(OFS_FRAME_INDEX, 32'hFFFFFFFF, f + 32'h1);
    end
  endtask
  task automatic t_flags;
    logic [11:0] evs [7] = '{12'h010, 12'h020, 12'h100, 12'h200, 12'h008, 12'h0C0, 12'h030};
    logic [31:0] exs [7] = '{32'h01, 32'h02, 32'h04, 32'h10, 32'h01, 32'h04, 32'h03};
    for (int k = 0; k < 7; k++) begin
      wr(OFS_STATUS, 32'h3F);
      pulse(evs[k]);
      rdm(OFS_STATUS, 32'h3F, exs[k]);
    end
    wr(OFS_STATUS, 32'h0);
    rdm(OFS_STATUS, 32'h3F, 32'h03);
    wr(OFS_STATUS, 32'h01);
    rdm(OFS_STATUS, 32'h3F, 32'h02);
    pulse(12'h400);
    rdm(OFS_STATUS, 32'h20, 32'h0);
    wr(OFS_CONTROL, ctl(1'b1, SIZE_1024, 1'b1, 1'b1, 1'b1));
    rdm(OFS_CONTROL, 32'h40, 32'h40);
    pulse(12'h400);
    rdm(OFS_STATUS, 32'h20, 32'h20);
    rdm(OFS_CONTROL, 32'h40, 32'h0);
  endtask
  task automatic t_irq;
    wr(OFS_STATUS, 32'h3F);
    wr(OFS_IRQ_EN, 32'h10);
    pulse(12'h200);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_STATUS, 32'h10);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_EN, 32'h01);
    pulse(12'h010);
    chk({31'h0, irq}, 32'h0);
    uf(8);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_STATUS, 32'h01);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_EN, 32'h0);
    pulse(12'h200);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_halt;
    cmd <= uhs_event_t'(12'h004);
    repeat (3) @(posedge clk);
    rdm(OFS_STATUS, 32'h2000, 32'h2000);
    cmd <= '0;
    slow <= 1'b1;
    wr(OFS_CONTROL, ctl(1'b0, SIZE_1024, 1'b1, 1'b1, 1'b0));
    uf(14);
    chk({31'h0, halted}, 32'h0);
    uf(1);
    chk({31'h0, halted}, 32'h1);
    rdm(OFS_STATUS, 32'hF000, 32'h1000);
    slow <= 1'b0;
    wr(OFS_CONTROL, ctl(1'b1, SIZE_1024, 1'b1, 1'b1, 1'b0));
    chk({31'h0, halted}, 32'h0);
    pulse(12'h001);
    repeat (6) @(posedge clk);
    chk({30'h0, run, halted}, 32'h1);
  endtask
  // ********************************************************************
  // clock, watchdog and main sequence
  // ********************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    mismatches++;
    stop_test;
  end
  initial begin
    rstn = 1'b0;
    slow = 1'b0;
    clk_en = 1'b1;
    req = '0;
    cmd = '0;
    mismatches = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset;
    t_regs;
    t_run;
    t_roll;
    t_flags;
    t_irq;
    t_halt;
    stop_test;
  end
endmodule
`default_nettype wire
